//--- hdl/csc_top.sv
/*
  Clock source control and status: oscillator and bus divider control,
  internal reference trim, and clock status with fine trim, behind AXI4-Lite.
  Assumes the loop, the oscillator and the reference clocks live outside and
  deliver their ticks as one-cycle enables on this clock; only the oscillator
  ready and the external reference present levels come asynchronously.
*/
// Notes on behaviour
// - Bus clock is the selected clock divided by 1, 2, 4 or 8.
// - Bus divider field resets to code 01, divide by two.
// - High range bit picks the oscillator's high frequency band.
// - High gain bit picks high gain, else low power oscillator operation.
// - Power-down bit disables loop in bypass modes unless debug active.
// - Source bit requests crystal oscillator when one, external clock when zero.
// - Output enable bit drives the external reference clock out.
// - External reference runs in stop if kept and enabled or external mode.
// - Eight-bit trim sets reference period, binary weighted.
// - Larger trim lengthens the reference period.
// - Internal-reference status follows the select only after synchronisation.
// - Mode status follows source select only after synchronisation.
// - Oscillator-done sets after start-up when oscillator requested and used.
// - Oscillator-done clears only when output enable or source bit clears.
// - Fine bit adds the smallest step to the reference period.
// - Source select chooses loop, internal or external clock for divider.
// - Low-power bypass only without debug and with power-down bit set.
// - Bus divider writes act immediately.
// - Coarse and fine trim survive system reset; only power-on reset reloads them, trim to 80h and fine bit to zero.
`timescale 1ns/1ps
module csc_top
  import csc_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              reset_n,
  input  wire logic              power_on_reset_n,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              background_debug_active,
  input  wire logic              stop_mode,
  input  wire logic              osc_ready_async,
  input  wire logic              ext_ref_present_async,
  input  wire logic              loop_clock_tick,
  input  wire logic              int_ref_tick,
  input  wire logic              ext_ref_tick,
  output logic                   bus_clock_enable,
  output logic                   osc_high_range,
  output logic                   osc_high_gain,
  output logic                   osc_crystal_select,
  output logic                   ext_ref_clock_out,
  output logic                   ext_ref_run,
  output logic                   loop_enable,
  output logic [8:0]             int_ref_period_code
);

  // ----------------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------------
  csc_mode_e         clock_source_select_reg;
  logic              int_ref_select_reg;
  logic [1:0]        bus_divider_select_reg;
  logic              high_range_reg;
  logic              high_gain_select_reg;
  logic              loop_power_down_in_bypass_reg;
  logic              ext_ref_source_select_reg;
  logic              ext_ref_output_enable_reg;
  logic              ext_ref_stop_keep_reg;
  logic [7:0]        trim_reg;
  logic              fine_adjust_bit_reg;
  logic              int_ref_status_reg;
  csc_mode_e         clock_mode_status_reg;
  logic              osc_start_done_reg;
  csc_mode_e         mode_sync1_reg;
  csc_mode_e         mode_sync2_reg;
  logic              iref_sync1_reg;
  logic              iref_sync2_reg;
  logic              osc_ready_sync1_reg;
  logic              osc_ready_sync2_reg;
  logic              ext_present_sync1_reg;
  logic              ext_present_sync2_reg;
  logic              ext_mode_before_stop_reg;

  // ----------------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------------
  logic              aw_full_reg;
  logic              w_full_reg;
  logic [ADDR_W-1:0] waddr_reg;
  logic [7:0]        wdata_reg;
  logic              wstrb0_reg;
  logic              do_write;
  logic              wr_ctrl1;
  logic              wr_ctrl2;
  logic              wr_trim;
  logic              wr_stat;

  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    is_mapped = (a == OFS_SOURCE_CTRL) || (a == OFS_OSC_DIV_CTRL) ||
                (a == OFS_REF_TRIM) || (a == OFS_STATUS_FINE);
  endfunction : is_mapped

  assign s_axi_awready = !aw_full_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_full_reg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_write      = aw_full_reg && w_full_reg && !s_axi_bvalid;
  assign wr_ctrl1      = do_write && wstrb0_reg && (waddr_reg == OFS_SOURCE_CTRL);
  assign wr_ctrl2      = do_write && wstrb0_reg && (waddr_reg == OFS_OSC_DIV_CTRL);
  assign wr_trim       = do_write && wstrb0_reg && (waddr_reg == OFS_REF_TRIM);
  assign wr_stat       = do_write && wstrb0_reg && (waddr_reg == OFS_STATUS_FINE);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      aw_full_reg  <= 1'b0;
      w_full_reg   <= 1'b0;
      waddr_reg    <= OFS_SOURCE_CTRL;
      wdata_reg    <= 8'h00;
      wstrb0_reg   <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_reg <= 1'b1;
        waddr_reg   <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata[7:0];
        wstrb0_reg <= s_axi_wstrb[0];
      end
      if (do_write) begin
        aw_full_reg  <= 1'b0;
        w_full_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= is_mapped(waddr_reg) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      unique case (s_axi_araddr)
        OFS_SOURCE_CTRL:  s_axi_rdata <= {24'h0, clock_source_select_reg, 3'h0, int_ref_select_reg, 2'h0};
        OFS_OSC_DIV_CTRL: s_axi_rdata <= {24'h0, bus_divider_select_reg, high_range_reg, high_gain_select_reg,
                                          loop_power_down_in_bypass_reg, ext_ref_source_select_reg,
                                          ext_ref_output_enable_reg, ext_ref_stop_keep_reg};
        OFS_REF_TRIM:     s_axi_rdata <= {24'h0, trim_reg};
        // Reserved bits read back as zero whatever software wrote.
        OFS_STATUS_FINE:  s_axi_rdata <= {27'h0, int_ref_status_reg, clock_mode_status_reg,
                                          osc_start_done_reg, fine_adjust_bit_reg};
        default:          s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Software controls
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      clock_source_select_reg <= CSC_MODE_LOOP;
      int_ref_select_reg      <= 1'b1;
    end else if (wr_ctrl1) begin
      // The reserved source code is stored as loop output.
      clock_source_select_reg <= (wdata_reg[SRC_SEL_MSB:SRC_SEL_LSB] == CSC_MODE_RSVD) ? CSC_MODE_LOOP :
                                 csc_mode_e'(wdata_reg[SRC_SEL_MSB:SRC_SEL_LSB]);
      int_ref_select_reg      <= wdata_reg[INT_REF_SEL];
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      bus_divider_select_reg        <= BUS_DIVIDER_SELECT_RESET;
      high_range_reg                <= 1'b0;
      high_gain_select_reg          <= 1'b0;
      loop_power_down_in_bypass_reg <= 1'b0;
      ext_ref_source_select_reg     <= 1'b0;
      ext_ref_output_enable_reg     <= 1'b0;
      ext_ref_stop_keep_reg         <= 1'b0;
    end else if (wr_ctrl2) begin
      bus_divider_select_reg        <= wdata_reg[BUS_DIVIDER_SELECT_MSB:BUS_DIVIDER_SELECT_LSB];
      high_range_reg                <= wdata_reg[HIGH_RANGE_BIT];
      high_gain_select_reg          <= wdata_reg[HIGH_GAIN_BIT];
      loop_power_down_in_bypass_reg <= wdata_reg[LOOP_PD_BIT];
      ext_ref_source_select_reg     <= wdata_reg[EXT_SRC_BIT];
      ext_ref_output_enable_reg     <= wdata_reg[EXT_OE_BIT];
      ext_ref_stop_keep_reg         <= wdata_reg[EXT_KEEP_BIT];
    end
  end

  // Trim lives on the power-on reset only, so a system reset keeps it.
  always_ff @(posedge clock or negedge power_on_reset_n) begin
    if (!power_on_reset_n) begin
      trim_reg            <= TRIM_RESET;
      fine_adjust_bit_reg <= 1'b0;
    end else begin
      if (wr_trim) begin
        trim_reg <= wdata_reg;
      end
      if (wr_stat) begin
        fine_adjust_bit_reg <= wdata_reg[FINE_BIT];
      end
    end
  end

  // Trim is the high bits and fine trim the smallest step of one period code.
  assign int_ref_period_code = {trim_reg, fine_adjust_bit_reg};
  assign osc_high_range      = high_range_reg;
  assign osc_high_gain       = high_gain_select_reg;
  assign osc_crystal_select  = ext_ref_source_select_reg;

  // ----------------------------------------------------------------------
  // Synchronised status
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      mode_sync1_reg        <= CSC_MODE_LOOP;
      mode_sync2_reg        <= CSC_MODE_LOOP;
      iref_sync1_reg        <= 1'b1;
      iref_sync2_reg        <= 1'b1;
      osc_ready_sync1_reg   <= 1'b0;
      osc_ready_sync2_reg   <= 1'b0;
      ext_present_sync1_reg <= 1'b0;
      ext_present_sync2_reg <= 1'b0;
    end else begin
      mode_sync1_reg        <= clock_source_select_reg;
      mode_sync2_reg        <= mode_sync1_reg;
      iref_sync1_reg        <= int_ref_select_reg;
      iref_sync2_reg        <= iref_sync1_reg;
      osc_ready_sync1_reg   <= osc_ready_async;
      osc_ready_sync2_reg   <= osc_ready_sync1_reg;
      ext_present_sync1_reg <= ext_ref_present_async;
      ext_present_sync2_reg <= ext_present_sync1_reg;
    end
  end

  // A switch to an external clock that is absent leaves the old mode in place.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      clock_mode_status_reg <= CSC_MODE_LOOP;
      int_ref_status_reg    <= 1'b1;
    end else begin
      if (mode_sync2_reg != CSC_MODE_EXT_BYP || ext_present_sync2_reg) begin
        clock_mode_status_reg <= mode_sync2_reg;
      end
      if (iref_sync2_reg || ext_present_sync2_reg) begin
        int_ref_status_reg <= iref_sync2_reg;
      end
    end
  end

  logic ext_ref_used;
  logic ext_engaged_mode;
  assign ext_engaged_mode = (clock_mode_status_reg == CSC_MODE_LOOP) && !int_ref_status_reg;
  assign ext_ref_used     = ext_ref_output_enable_reg || ext_engaged_mode ||
                            (clock_mode_status_reg == CSC_MODE_EXT_BYP);

  // Set wins over clear; clearing needs the enable or the source bit low.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      osc_start_done_reg <= 1'b0;
    end else if (osc_ready_sync2_reg && ext_ref_source_select_reg && ext_ref_used) begin
      osc_start_done_reg <= 1'b1;
    end else if (!ext_ref_output_enable_reg || !ext_ref_source_select_reg) begin
      osc_start_done_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Loop, reference and bus clock gating
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ext_mode_before_stop_reg <= 1'b0;
    end else if (!stop_mode) begin
      ext_mode_before_stop_reg <= ext_engaged_mode || (clock_mode_status_reg == CSC_MODE_EXT_BYP);
    end
  end

  assign loop_enable = !((clock_mode_status_reg == CSC_MODE_INT_BYP ||
                          clock_mode_status_reg == CSC_MODE_EXT_BYP) &&
                         loop_power_down_in_bypass_reg && !background_debug_active) && !stop_mode;
  assign ext_ref_run = stop_mode ? (ext_ref_stop_keep_reg &&
                                    (ext_ref_output_enable_reg || ext_mode_before_stop_reg)) :
                                   ext_ref_used;
  assign ext_ref_clock_out = ext_ref_output_enable_reg && ext_ref_run;

  csc_div_if div_bus ();

  always_comb begin
    unique case (clock_mode_status_reg)
      CSC_MODE_INT_BYP: div_bus.src_tick = int_ref_tick;
      CSC_MODE_EXT_BYP: div_bus.src_tick = ext_ref_tick;
      default:          div_bus.src_tick = loop_clock_tick;
    endcase
  end
  assign div_bus.div_code = bus_divider_select_reg;
  assign bus_clock_enable = div_bus.bus_tick && !stop_mode;

  csc_bus_div u_bus_div (
    .clock   (clock),
    .reset_n (reset_n),
    .dv      (div_bus.div)
  );

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  property p_range_follows_write;
    @(posedge clock) disable iff (!reset_n)
      wr_ctrl2 |=> osc_high_range == $past(wdata_reg[HIGH_RANGE_BIT]);
  endproperty
  a_range_follows_write: assert property (p_range_follows_write)
    else $error("oscillator range did not follow the write");

  property p_gain_follows_write;
    @(posedge clock) disable iff (!reset_n)
      wr_ctrl2 ##1 !wr_ctrl2 |-> osc_high_gain == $past(wdata_reg[HIGH_GAIN_BIT], 1);
  endproperty
  a_gain_follows_write: assert property (p_gain_follows_write)
    else $error("oscillator gain did not follow the write");

  property p_loop_off_in_lp_bypass;
    @(posedge clock) disable iff (!reset_n)
      (clock_mode_status_reg == CSC_MODE_EXT_BYP) && loop_power_down_in_bypass_reg &&
      !background_debug_active |-> !loop_enable;
  endproperty
  a_loop_off_in_lp_bypass: assert property (p_loop_off_in_lp_bypass)
    else $error("loop still enabled in low-power bypass");

  property p_ext_out_gated;
    @(posedge clock) disable iff (!reset_n)
      !ext_ref_output_enable_reg |-> !ext_ref_clock_out;
  endproperty
  a_ext_out_gated: assert property (p_ext_out_gated)
    else $error("external reference out without its enable");

  property p_stop_without_keep;
    @(posedge clock) disable iff (!reset_n)
      stop_mode && !ext_ref_stop_keep_reg |-> !ext_ref_run && !bus_clock_enable;
  endproperty
  a_stop_without_keep: assert property (p_stop_without_keep)
    else $error("external reference runs in stop without keep");

  property p_int_status_lag;
    @(posedge clock) disable iff (!reset_n)
      $changed(int_ref_status_reg) |-> int_ref_status_reg == $past(int_ref_select_reg, 3);
  endproperty
  a_int_status_lag: assert property (p_int_status_lag)
    else $error("reference status did not lag the select by three cycles");

  property p_mode_status_lag;
    @(posedge clock) disable iff (!reset_n)
      $changed(clock_mode_status_reg) |-> clock_mode_status_reg == $past(clock_source_select_reg, 3);
  endproperty
  a_mode_status_lag: assert property (p_mode_status_lag)
    else $error("mode status did not lag the select by three cycles");

  property p_osc_done_clear;
    @(posedge clock) disable iff (!reset_n)
      $fell(osc_start_done_reg) |-> $past(!ext_ref_output_enable_reg || !ext_ref_source_select_reg);
  endproperty
  a_osc_done_clear: assert property (p_osc_done_clear)
    else $error("oscillator done cleared without cause");

endmodule : csc_top

//--- hdl/csc_pkg.sv
/*
  Shared constants and types of the clock source control and status block:
  register byte offsets, field positions, reset values and mode codes.
  Assumes a 32-bit AXI4-Lite register bus with the registers in the low byte.
*/
package csc_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam int          ADDR_W            = 4;
  localparam logic [3:0]  OFS_SOURCE_CTRL   = 4'h0;
  localparam logic [3:0]  OFS_OSC_DIV_CTRL  = 4'h4;
  localparam logic [3:0]  OFS_REF_TRIM      = 4'h8;
  localparam logic [3:0]  OFS_STATUS_FINE   = 4'hC;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int SRC_SEL_MSB    = 7;
  localparam int SRC_SEL_LSB    = 6;
  localparam int INT_REF_SEL    = 2;
  localparam int BUS_DIVIDER_SELECT_MSB       = 7;
  localparam int BUS_DIVIDER_SELECT_LSB       = 6;
  localparam int HIGH_RANGE_BIT = 5;
  localparam int HIGH_GAIN_BIT  = 4;
  localparam int LOOP_PD_BIT    = 3;
  localparam int EXT_SRC_BIT    = 2;
  localparam int EXT_OE_BIT     = 1;
  localparam int EXT_KEEP_BIT   = 0;
  localparam int INT_STAT_BIT   = 4;
  localparam int MODE_STAT_MSB  = 3;
  localparam int MODE_STAT_LSB  = 2;
  localparam int OSC_DONE_BIT   = 1;
  localparam int FINE_BIT       = 0;

  // ----------------------------------------------------------------------
  // Reset values and bus answers
  // ----------------------------------------------------------------------
  localparam logic [1:0]  BUS_DIVIDER_SELECT_RESET     = 2'h1;
  localparam logic [7:0]  TRIM_RESET     = 8'h80;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;
  localparam logic [2:0]  DIV_CNT_ZERO   = 3'h0;
  localparam logic [2:0]  DIV_CNT_ONE    = 3'h1;

  typedef enum logic [1:0] {
    CSC_MODE_LOOP    = 2'b00,
    CSC_MODE_INT_BYP = 2'b01,
    CSC_MODE_EXT_BYP = 2'b10,
    CSC_MODE_RSVD    = 2'b11
  } csc_mode_e;

endpackage : csc_pkg

//--- hdl/csc_div_if.sv
/*
  Interface between the control block and its bus clock divider.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface csc_div_if;
  logic       src_tick;
  logic [1:0] div_code;
  logic       bus_tick;
  modport ctrl (output src_tick, output div_code, input bus_tick);
  modport div  (input src_tick, input div_code, output bus_tick);
endinterface : csc_div_if

//--- hdl/csc_bus_div.sv
/*
  Bus clock divider: passes every 1st, 2nd, 4th or 8th tick of the selected
  source as a one-cycle bus clock enable.
  Assumes the source tick is a one-cycle enable on the same clock.
*/
`timescale 1ns/1ps
module csc_bus_div
  import csc_pkg::*;
(
  input  wire logic clock,
  input  wire logic reset_n,
  csc_div_if.div    dv
);

  logic [2:0] count_reg;
  logic       at_limit;

  function automatic logic [2:0] div_limit(input logic [1:0] code);
    div_limit = 3'((4'h1 << code) - 4'h1);
  endfunction : div_limit

  // A new code takes effect on the very next source tick, with no resync.
  assign at_limit    = (count_reg >= div_limit(dv.div_code));
  assign dv.bus_tick = dv.src_tick && at_limit;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      count_reg <= DIV_CNT_ZERO;
    end else if (dv.src_tick) begin
      count_reg <= at_limit ? DIV_CNT_ZERO : count_reg + DIV_CNT_ONE;
    end
  end

  property p_div_tick_source;
    @(posedge clock) disable iff (!reset_n)
      dv.bus_tick |-> dv.src_tick;
  endproperty
  a_div_tick_source: assert property (p_div_tick_source)
    else $error("bus tick without a source tick");

  property p_div_by_one;
    @(posedge clock) disable iff (!reset_n)
      (dv.div_code == 2'h0) && dv.src_tick |-> dv.bus_tick;
  endproperty
  a_div_by_one: assert property (p_div_by_one)
    else $error("divide by one dropped a source tick");

endmodule : csc_bus_div

//--- verif/tb_top.sv
/* Self-checking bench of the clock source control block: register bus,
   bus divider, trim, status and loop gating.
   Assumes csc_pkg and csc_top are compiled before it. */
`timescale 1ns/1ps
module tb_top
  import csc_pkg::*;
;
  logic clock, reset_n, power_on_reset_n, background_debug_active, stop_mode;
  logic osc_ready_async, ext_ref_present_async, loop_clock_tick, int_ref_tick, ext_ref_tick;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rd_resp, wr_resp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, bus_clock_enable, f, ta, tw;
  logic osc_high_range, osc_high_gain, osc_crystal_select, ext_ref_clock_out, ext_ref_run, loop_enable;
  logic [8:0] int_ref_period_code;
  logic [7:0] rd_data, r, t;
  int n, fails, checks;
  csc_top csc_top_i (.*);
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // Reference ticks arrive at random so the divider sees gaps.
  always @(posedge clock) begin
    int_ref_tick <= 1'($urandom);
    ext_ref_tick <= 1'($urandom);
  end
  function automatic logic [7:0] st(input logic i, input logic [1:0] m, input logic o, input logic fb);
    return {3'h0, i, m, o, fb};
  endfunction : st
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic end_sim;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge clock);
      ta = s_axi_awready & s_axi_awvalid;
      tw = s_axi_wready & s_axi_wvalid;
      @(posedge clock);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end while (s_axi_awvalid & !ta | s_axi_wvalid & !tw);
    do begin
      @(negedge clock);
      ta = s_axi_bvalid;
      wr_resp = s_axi_bresp;
      @(posedge clock);
    end while (!ta);
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge clock);
      ta = s_axi_arready;
      @(posedge clock);
    end while (!ta);
    s_axi_arvalid <= 1'b0;
    do begin
      @(negedge clock);
      ta = s_axi_rvalid;
      rd_data = s_axi_rdata[7:0];
      rd_resp = s_axi_rresp;
      @(posedge clock);
    end while (!ta);
    s_axi_rready <= 1'b0;
  endtask : rd
  initial begin
    {reset_n, power_on_reset_n, background_debug_active, stop_mode, s_axi_awvalid} = '0;
    {s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
    {s_axi_wdata, checks, fails} = '0;
    {osc_ready_async, ext_ref_present_async, loop_clock_tick, s_axi_wstrb} = 7'h7F;
    void'($urandom(53));
    repeat (4) @(posedge clock);
    reset_n <= 1'b1;
    power_on_reset_n <= 1'b1;
    rd(OFS_OSC_DIV_CTRL); chk(rd_data, 8'h40);
    rd(OFS_STATUS_FINE); chk(rd_data, st(1'b1, 2'h0, 1'b0, 1'b0));
    for (int c = 0; c < 4; c++) begin
      wr(OFS_OSC_DIV_CTRL, {2'(c), 6'h0});
      n = 0;
      repeat (64) begin
        @(negedge clock);
        n += int'(bus_clock_enable);
      end
      chk(9'(n), 9'(64 >> c));
    end
    for (int k = 0; k < 6; k++) begin
      r = (k == 0) ? 8'h06 : 8'($urandom);
      wr(OFS_OSC_DIV_CTRL, r);
      repeat (4) @(posedge clock);
      @(negedge clock);
      chk({osc_high_range, osc_high_gain, osc_crystal_select}, {r[5:4], r[2]});
      chk({ext_ref_clock_out, ext_ref_run, loop_enable}, {r[1], r[1], 1'b1});
      rd(OFS_STATUS_FINE); chk(rd_data, st(1'b1, 2'h0, r[2] & r[1], 1'b0));
    end
    t = 8'($urandom);
    f = 1'($urandom);
    wr(OFS_REF_TRIM, t);
    chk(wr_resp, RESP_OKAY);
    wr(OFS_STATUS_FINE, {7'h0, f});
    chk(int_ref_period_code, {t, f});
    @(posedge clock);
    reset_n <= 1'b0;
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    chk(int_ref_period_code, {t, f});
    wr(OFS_SOURCE_CTRL, 8'h44);
    wr(OFS_OSC_DIV_CTRL, 8'h08);
    repeat (6) @(posedge clock);
    chk(loop_enable, 1'b0);
    repeat (8) begin
      @(negedge clock); chk(bus_clock_enable, int_ref_tick);
    end
    background_debug_active <= 1'b1;
    @(negedge clock); chk(loop_enable, 1'b1);
    background_debug_active <= 1'b0;
    rd(OFS_STATUS_FINE); chk(rd_data, st(1'b1, 2'h1, 1'b0, f));
    wr(OFS_SOURCE_CTRL, 8'h80);
    repeat (6) @(posedge clock);
    rd(OFS_STATUS_FINE); chk(rd_data, st(1'b0, 2'h2, 1'b0, f));
    repeat (8) begin
      @(negedge clock); chk(bus_clock_enable, ext_ref_tick);
    end
    rd(4'h2); chk(rd_resp, RESP_SLVERR);
    wr(4'h2, 8'hFF); chk(wr_resp, RESP_SLVERR);
    for (int k = 0; k < 2; k++) begin
      wr(OFS_OSC_DIV_CTRL, 8'h02 | 8'(k));
      stop_mode <= 1'b1;
      @(negedge clock); chk({ext_ref_clock_out, ext_ref_run, bus_clock_enable}, {1'(k), 1'(k), 1'b0});
      stop_mode <= 1'b0;
    end
    end_sim();
  end
  initial begin
    repeat (20000) @(posedge clock);
    fails++;
    end_sim();
  end
endmodule : tb_top
